// ==== shared/cdfr_pkg.sv ====
// Constants shared by the coil driver fault/regulation control block.
// Assumes one 40 MHz clock and an AHB-Lite register port.
package cdfr_pkg;
    // -------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int OSC_REF_HZ = 8_000_000;
    localparam int BOOST_HZ = 125_000;
    // Reference ratio scaled by the clock ratio, so the rate is unchanged
    localparam int BOOST_DIV = OSC_REF_HZ / BOOST_HZ * (CLK_HZ / OSC_REF_HZ);
    localparam int BOOST_HALF = BOOST_DIV / 2;
    // -------------------------------------------------------------
    // Register byte addresses
    // -------------------------------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STEP = 8'h04;
    localparam logic [7:0] A_STAT = 8'h08;
    localparam logic [7:0] A_FAULT = 8'h0C;
    localparam logic [7:0] A_ISTAT = 8'h10;
    localparam logic [7:0] A_IMASK = 8'h14;
    localparam logic [7:0] A_DIAG = 8'h18;
    // -------------------------------------------------------------
    // Fields
    // -------------------------------------------------------------
    localparam int CH_N = 6;
    localparam int CTL_TX = 0;
    localparam int CTL_DIAG = 1;
    localparam int CTL_SEL_LO = 2;
    localparam int F_SBAT = 6;
    localparam int F_SGND = 7;
    localparam int F_OPEN = 8;
    localparam int F_OTMP = 9;
    localparam int I_FAULT = 0;
    localparam int I_OVP = 1;
    localparam int I_W = 2;
    localparam logic [4:0] STEP_TOP = 5'h13;
    localparam logic [4:0] STEP_RST = 5'h00;
    localparam logic [2:0] SEL_RST = 3'h0;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
    localparam logic [1:0] HTRANS_NSEQ = 2'h2;
    // Operating states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_TX = 2'b01,
        ST_SHUT = 2'b10,
        ST_DIAG = 2'b11
    } cdfr_state_type;
endpackage

// ==== shared/cdfr_core_if.sv ====
// Carrier between the control core and its timing helpers.
// Assumes all members live on the single system clock.
`timescale 1ns/1ps
interface cdfr_core_if;
    logic boost_run;
    logic over_volt;
    logic boost_clk;
    logic zc_level;
    logic sample_pulse;
    modport boost (input boost_run, input over_volt, output boost_clk);
    modport peak (input zc_level, input boost_run, output sample_pulse);
    modport core (output boost_run, output over_volt, output zc_level,
        input boost_clk, input sample_pulse);
endinterface

// ==== hdl/cdfr_boost_clk.sv ====
// Boost converter switching clock, divided from the system clock.
// Assumes boost_run already folds in transmit state and fault state.
`timescale 1ns/1ps
module cdfr_boost_clk #(
    parameter int HALF = cdfr_pkg::BOOST_HALF
) (
    // System
    input wire logic hclk,
    input wire logic hresetn,
    // Core link
    cdfr_core_if.boost cif
);
    logic [15:0] cnt_reg;
    logic clk_reg;
    wire logic gate_on = cif.boost_run && !cif.over_volt;
    wire logic wrap = cnt_reg == 16'(HALF - 1);

    // Divider; held cleared when stopped so restart is a clean phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_reg <= 16'h0000;
            clk_reg <= 1'b0;
        end else if (!gate_on) begin
            cnt_reg <= 16'h0000;
            clk_reg <= 1'b0;
        end else begin
            cnt_reg <= wrap ? 16'h0000 : cnt_reg + 16'h0001;
            clk_reg <= wrap ? !clk_reg : clk_reg;
        end
    end
    assign cif.boost_clk = clk_reg;
endmodule

// ==== hdl/cdfr_peak_timer.sv ====
// Times the positive current peak a quarter period after the
// rising zero crossing of the shunt sense comparator.
// Assumes the comparator level is synchronous and glitch free.
`timescale 1ns/1ps
module cdfr_peak_timer #(
    parameter int CW = 12
) (
    // System
    input wire logic hclk,
    input wire logic hresetn,
    // Core link
    cdfr_core_if.peak cif
);
    logic zc_d_reg;
    logic [CW-1:0] per_reg;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] quarter_reg;
    logic armed_reg;
    logic pulse_reg;
    wire logic rise = cif.zc_level && !zc_d_reg;
    wire logic hit = armed_reg && cnt_reg == quarter_reg;

    // Period measured between rising crossings, peak at one quarter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            zc_d_reg <= 1'b0;
            per_reg <= '0;
            cnt_reg <= '0;
            quarter_reg <= '0;
            armed_reg <= 1'b0;
            pulse_reg <= 1'b0;
        end else begin
            zc_d_reg <= cif.zc_level;
            cnt_reg <= rise ? '0 : cnt_reg + 1'b1;
            per_reg <= rise ? cnt_reg : per_reg;
            quarter_reg <= rise ? (cnt_reg >> 2) : quarter_reg;
            armed_reg <= rise ? cif.boost_run && per_reg != '0
                : armed_reg && !hit;
            pulse_reg <= hit && cif.boost_run;
        end
    end
    assign cif.sample_pulse = pulse_reg;
endmodule

// ==== hdl/cdfr_ctrl.sv ====
// Coil driver control: transmit state, fault shutdown, current
// step, boost gating, peak sampling and line test structures.
// Assumes AHB-Lite single word transfers and synchronous inputs.
//
// How it works
// - Boost switching clock divided down from the system clock, 125 kHz.
// - Boost switching runs only while a transmission is active.
// - Boost stops whenever the overvoltage flag is high.
// - Twenty current steps, codes 0 to 19, lowest first.
// - Any step accepted for any channel, never refused.
// - Peak sample timed from rising zero crossings of the shunt sense.
// - A line of an unblocked coil shorted to battery or ground puts all drivers hi-z.
// - Fault shutdown disconnects the shunt from all return lines.
// - Fault shutdown records cause and channel in the fault register.
// - Fault shutdown raises the interrupt request.
// - Open load or overtemperature shuts down the same way.
// - Fault conditions are checked every cycle in normal operation.
// - Writing the fault register clears it; healthy coils may transmit.
// - Test switches per line set and read back by software.
// - In shutdown, bus works, stages off, transmit requests ignored.
`timescale 1ns/1ps
module cdfr_ctrl (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Line monitors
    input wire logic [5:0] pos_short_bat,
    input wire logic [5:0] pos_short_gnd,
    input wire logic [5:0] neg_short_bat,
    input wire logic [5:0] neg_short_gnd,
    input wire logic [5:0] open_load,
    input wire logic over_temp,
    input wire logic boost_over_volt,
    input wire logic shunt_zero_cross,
    input wire logic [5:0] diag_level_p,
    input wire logic [5:0] diag_level_n,
    // Power stage controls
    output logic [5:0] driver_en,
    output logic driver_hiz,
    output logic shunt_connect,
    output logic boost_switch,
    output logic [4:0] current_step,
    output logic peak_sample,
    output logic [5:0] diag_hi_p,
    output logic [5:0] diag_hi_n,
    // Interrupt
    output logic irq
);
    // -------------------------------------------------------------
    // Bus slave
    // -------------------------------------------------------------
    cdfr_pkg::cdfr_state_type st_reg, st_next;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [31:0] rdata_reg;
    logic [2:0] ctl_sel_reg;
    logic ctl_diag_reg;
    logic [4:0] step_reg;
    logic [9:0] fault_reg;
    logic [5:0] block_reg;
    logic [cdfr_pkg::I_W-1:0] istat_reg, imask_reg;
    logic irq_reg;
    logic [5:0] en_reg, hi_p_reg, hi_n_reg;
    logic hiz_reg, shunt_reg, peak_reg;
    logic [4:0] step_out_reg;

    // Address phase decode
    wire logic acc = hsel && hready && htrans == cdfr_pkg::HTRANS_NSEQ;
    wire logic rd_now = acc && !hwrite;
    wire logic wr_now = wr_pend_reg;
    wire logic wr_ctrl = wr_now && wr_addr_reg == cdfr_pkg::A_CTRL;
    wire logic wr_step = wr_now && wr_addr_reg == cdfr_pkg::A_STEP;
    wire logic wr_fault = wr_now && wr_addr_reg == cdfr_pkg::A_FAULT;
    wire logic wr_imask = wr_now && wr_addr_reg == cdfr_pkg::A_IMASK;
    wire logic wr_diag = wr_now && wr_addr_reg == cdfr_pkg::A_DIAG;
    wire logic rd_istat = rd_now && haddr == cdfr_pkg::A_ISTAT;

    // Write data fields
    wire logic w_tx = hwdata[cdfr_pkg::CTL_TX];
    wire logic w_diag = hwdata[cdfr_pkg::CTL_DIAG];
    wire logic [2:0] w_sel = hwdata[cdfr_pkg::CTL_SEL_LO +: 3];

    // -------------------------------------------------------------
    // Fault evaluation
    // -------------------------------------------------------------
    // Checked every cycle in idle and transmit; blocked coils are skipped
    wire logic [5:0] live = ~block_reg;
    wire logic normal = st_reg == cdfr_pkg::ST_IDLE
        || st_reg == cdfr_pkg::ST_TX;
    // A select written with the request counts in that same cycle
    wire logic sel_wr = wr_ctrl && (st_reg == cdfr_pkg::ST_IDLE
        || st_reg == cdfr_pkg::ST_DIAG);
    wire logic [2:0] sel_now = sel_wr ? w_sel : ctl_sel_reg;
    wire logic [5:0] ch_hot = 6'(1) << sel_now;
    wire logic [5:0] sbat = (pos_short_bat | neg_short_bat) & live;
    wire logic [5:0] sgnd = (pos_short_gnd | neg_short_gnd) & live;
    wire logic [5:0] opn = st_reg == cdfr_pkg::ST_TX
        ? open_load & ch_hot : 6'h00;
    wire logic [5:0] bad_ch = sbat | sgnd | opn;
    wire logic trip = normal && (|bad_ch || over_temp);
    wire logic [9:0] cause = {over_temp, |opn, |sgnd, |sbat, bad_ch};

    // Transmit request is honoured only from idle on a healthy coil
    wire logic sel_ok = !(|(ch_hot & block_reg));
    wire logic sel_valid = sel_now < 3'(cdfr_pkg::CH_N);

    // State transitions
    always_comb begin
        st_next = st_reg;
        unique case (st_reg)
            cdfr_pkg::ST_IDLE: begin
                if (wr_ctrl && w_diag)
                    st_next = cdfr_pkg::ST_DIAG;
                else if (wr_ctrl && w_tx)
                    st_next = cdfr_pkg::ST_TX;
            end
            cdfr_pkg::ST_TX: begin
                if (wr_ctrl && !w_tx)
                    st_next = cdfr_pkg::ST_IDLE;
            end
            cdfr_pkg::ST_SHUT: begin
                // Only the clear leaves here
                if (wr_fault)
                    st_next = cdfr_pkg::ST_IDLE;
            end
            cdfr_pkg::ST_DIAG: begin
                if (wr_ctrl && !w_diag)
                    st_next = cdfr_pkg::ST_IDLE;
            end
        endcase
        if (trip)
            st_next = cdfr_pkg::ST_SHUT;
        if (st_next == cdfr_pkg::ST_TX && !(sel_ok && sel_valid))
            st_next = cdfr_pkg::ST_IDLE;
    end

    // Helper link to the timing modules
    cdfr_core_if cif ();
    assign cif.boost_run = st_reg == cdfr_pkg::ST_TX;
    assign cif.over_volt = boost_over_volt;
    assign cif.zc_level = shunt_zero_cross;

    cdfr_boost_clk u_boost (
        .hclk(hclk),
        .hresetn(hresetn),
        .cif(cif)
    );
    cdfr_peak_timer u_peak (
        .hclk(hclk),
        .hresetn(hresetn),
        .cif(cif)
    );

    // Read mux and events
    wire logic [31:0] rd_mux =
        haddr == cdfr_pkg::A_CTRL ? 32'({ctl_sel_reg, ctl_diag_reg,
            st_reg == cdfr_pkg::ST_TX}) :
        haddr == cdfr_pkg::A_STEP ? 32'(step_reg) :
        haddr == cdfr_pkg::A_STAT ? 32'({block_reg, st_reg}) :
        haddr == cdfr_pkg::A_FAULT ? 32'(fault_reg) :
        haddr == cdfr_pkg::A_ISTAT ? 32'(istat_reg) :
        haddr == cdfr_pkg::A_IMASK ? 32'(imask_reg) :
        haddr == cdfr_pkg::A_DIAG ? 32'({diag_level_n & ch_hot,
            diag_level_p & ch_hot}) : cdfr_pkg::ZERO32;
    wire logic ovp_ev = cif.boost_run && boost_over_volt;
    wire logic [cdfr_pkg::I_W-1:0] ev = {ovp_ev, trip};
    // Event wins over the read that clears it
    wire logic [cdfr_pkg::I_W-1:0] istat_next =
        (rd_istat ? '0 : istat_reg) | ev;
    wire logic irq_next = |(istat_next & imask_reg);

    // Clamp codes past the top step
    wire logic [4:0] step_eff = step_reg > cdfr_pkg::STEP_TOP
        ? cdfr_pkg::STEP_TOP : step_reg;

    // -------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------
    // Bus pipeline; zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= cdfr_pkg::A_CTRL;
            rdata_reg <= cdfr_pkg::ZERO32;
        end else begin
            wr_pend_reg <= acc && hwrite;
            wr_addr_reg <= acc ? haddr : wr_addr_reg;
            rdata_reg <= rd_now ? rd_mux : rdata_reg;
        end
    end

    // Software settings
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= cdfr_pkg::ST_IDLE;
            ctl_sel_reg <= cdfr_pkg::SEL_RST;
            ctl_diag_reg <= 1'b0;
            step_reg <= cdfr_pkg::STEP_RST;
            imask_reg <= '0;
        end else begin
            st_reg <= st_next;
            // Selection moves only in idle and in test mode
            ctl_sel_reg <= sel_now;
            ctl_diag_reg <= st_next == cdfr_pkg::ST_DIAG;
            // Any code stored, no group check
            if (wr_step)
                step_reg <= hwdata[4:0];
            if (wr_imask)
                imask_reg <= hwdata[cdfr_pkg::I_W-1:0];
        end
    end

    // Fault record, coil block list, interrupt
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_reg <= 10'h000;
            block_reg <= 6'h00;
            istat_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            // New cause outranks the clear in the same cycle
            if (trip)
                fault_reg <= cause;
            else if (wr_fault)
                fault_reg <= 10'h000;
            // Faulty coils stay barred until chip reset
            if (wr_fault && !trip)
                block_reg <= block_reg | fault_reg[5:0];
            istat_reg <= istat_next;
            irq_reg <= irq_next;
        end
    end

    // Power stage outputs, all registered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_reg <= 6'h00;
            hiz_reg <= 1'b1;
            shunt_reg <= 1'b0;
            peak_reg <= 1'b0;
            step_out_reg <= cdfr_pkg::STEP_RST;
        end else begin
            en_reg <= st_next == cdfr_pkg::ST_TX ? ch_hot : 6'h00;
            hiz_reg <= st_next == cdfr_pkg::ST_SHUT
                || st_next == cdfr_pkg::ST_DIAG;
            shunt_reg <= st_next != cdfr_pkg::ST_SHUT;
            peak_reg <= cif.sample_pulse;
            step_out_reg <= step_eff;
        end
    end

    // Latched test switches, one per line, changed only when selected
    genvar g;
    generate
        for (g = 0; g < cdfr_pkg::CH_N; g++) begin : g_diag
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    hi_p_reg[g] <= 1'b0;
                    hi_n_reg[g] <= 1'b0;
                end else if (wr_diag && st_reg == cdfr_pkg::ST_DIAG
                    && ctl_sel_reg == 3'(g)) begin
                    hi_p_reg[g] <= hwdata[0];
                    hi_n_reg[g] <= hwdata[1];
                end
            end
        end
    endgenerate

    assign hrdata = rdata_reg;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign driver_en = en_reg;
    assign driver_hiz = hiz_reg;
    assign shunt_connect = shunt_reg;
    assign boost_switch = cif.boost_clk;
    assign current_step = step_out_reg;
    assign peak_sample = peak_reg;
    assign diag_hi_p = hi_p_reg;
    assign diag_hi_n = hi_n_reg;
    assign irq = irq_reg;

    // -------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_trip_hiz;
        trip |=> driver_hiz && driver_en == 6'h00;
    endproperty
    a_trip_hiz: assert property (p_trip_hiz)
        else $error("drivers not off after fault");
    property p_trip_shunt;
        trip |=> !shunt_connect;
    endproperty
    a_trip_shunt: assert property (p_trip_shunt)
        else $error("shunt still connected after fault");
    property p_trip_cause;
        trip |=> fault_reg == $past(cause);
    endproperty
    a_trip_cause: assert property (p_trip_cause)
        else $error("fault cause not recorded");
    property p_trip_irq;
        trip && imask_reg[cdfr_pkg::I_FAULT] |=> irq;
    endproperty
    a_trip_irq: assert property (p_trip_irq)
        else $error("no interrupt after fault");
    property p_shut_stay;
        st_reg == cdfr_pkg::ST_SHUT && !wr_fault |=>
            st_reg == cdfr_pkg::ST_SHUT;
    endproperty
    a_shut_stay: assert property (p_shut_stay)
        else $error("shutdown left without clear");
    property p_clear;
        st_reg == cdfr_pkg::ST_SHUT && wr_fault && !trip |=>
            st_reg == cdfr_pkg::ST_IDLE && fault_reg == 10'h000;
    endproperty
    a_clear: assert property (p_clear)
        else $error("fault clear not honoured");
    property p_boost_idle;
        st_reg != cdfr_pkg::ST_TX [*2] |-> !boost_switch;
    endproperty
    a_boost_idle: assert property (p_boost_idle)
        else $error("boost switching outside transmission");
    property p_boost_ovp;
        boost_over_volt [*2] |-> !boost_switch;
    endproperty
    a_boost_ovp: assert property (p_boost_ovp)
        else $error("boost switching during overvoltage");
    property p_step_clamp;
        step_reg > cdfr_pkg::STEP_TOP |=>
            current_step == cdfr_pkg::STEP_TOP;
    endproperty
    a_step_clamp: assert property (p_step_clamp)
        else $error("step code not clamped");
    // A stop in mid half period cuts the phase short; not a fault
    wire logic boost_run_ok = cif.boost_run && !boost_over_volt;
    property p_boost_rate;
        @(posedge hclk) disable iff (!hresetn || !boost_run_ok)
        $rose(boost_switch) |-> ##159 boost_switch ##1 !boost_switch;
    endproperty
    a_boost_rate: assert property (p_boost_rate)
        else $error("boost half period wrong");

    c_tx: cover property (st_reg == cdfr_pkg::ST_TX ##1 boost_switch);
    c_trip: cover property (st_reg == cdfr_pkg::ST_TX ##1 trip);
    c_clear: cover property (wr_fault && st_reg == cdfr_pkg::ST_SHUT);
    c_peak: cover property (peak_sample);
endmodule

// ==== test/cdfr_plant.sv ====
// Coil, shunt and line plant that stands behind the control block.
// Assumes one clock; each line not grounded reads back its test switch level.
`timescale 1ns/1ps
module cdfr_plant #(
    parameter int ZC_PER = 400
) (
    // System
    input wire logic hclk,
    // From the block
    input wire logic [5:0] driver_en,
    input wire logic [5:0] diag_hi_p,
    input wire logic [5:0] diag_hi_n,
    // Fault injection
    input wire logic [5:0] p_to_gnd,
    // To the block
    output logic shunt_zero_cross,
    output logic [5:0] diag_level_p,
    output logic [5:0] diag_level_n
);
    // ------------------------------------------------------------
    // Behaviour
    // ------------------------------------------------------------
    int cnt = 0;
    initial shunt_zero_cross = 1'b0;
    // No coil current without a driver, so the sense stands low
    always @(posedge hclk) begin
        cnt <= (|driver_en) ? (cnt + 1) % ZC_PER : 0;
        shunt_zero_cross <= (|driver_en) && (cnt < ZC_PER / 2);
    end
    // A grounded line reads low whatever its source does
    assign diag_level_p = diag_hi_p & ~p_to_gnd;
    assign diag_level_n = diag_hi_n;
endmodule

// ==== test/cdfr_ctrl_bench.sv ====
// Self-checking bench for the coil driver control block.
// Assumes the plant model and a zero wait state AHB-Lite slave.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    error_cnt++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module cdfr_ctrl_bench;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [5:0] pos_short_bat = 6'h00, pos_short_gnd = 6'h00;
    logic [5:0] neg_short_bat = 6'h00, neg_short_gnd = 6'h00;
    logic [5:0] open_load = 6'h00, p_to_gnd = 6'h00;
    logic over_temp = 1'b0, boost_over_volt = 1'b0;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, shunt_zero_cross, driver_hiz, shunt_connect;
    logic boost_switch, peak_sample, irq;
    logic [5:0] diag_level_p, diag_level_n, driver_en, diag_hi_p;
    logic [5:0] diag_hi_n;
    logic [4:0] current_step;
    int error_cnt = 0, cmp_count = 0, n, c;
    typedef struct {logic [4:0] code; logic [4:0] eff;} cdfr_row_type;
    cdfr_row_type rows [5] = '{'{5'h00, 5'h00}, '{5'h07, 5'h07},
        '{5'h13, 5'h13}, '{5'h14, 5'h13}, '{5'h1F, 5'h13}};
    cdfr_ctrl u_cdfr_ctrl (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata,
        .hreadyout, .hresp, .pos_short_bat, .pos_short_gnd,
        .neg_short_bat, .neg_short_gnd, .open_load, .over_temp,
        .boost_over_volt, .shunt_zero_cross, .diag_level_p,
        .diag_level_n, .driver_en, .driver_hiz, .shunt_connect,
        .boost_switch, .current_step, .peak_sample, .diag_hi_p,
        .diag_hi_n, .irq);
    cdfr_plant u_cdfr_plant (.hclk, .driver_en, .diag_hi_p, .diag_hi_n,
        .p_to_gnd, .shunt_zero_cross, .diag_level_p, .diag_level_n);
    // Clock, 25 ns period
    initial forever #12.5 hclk = ~hclk;
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic cyc(input int k);
        repeat (k) @(posedge hclk);
    endtask
    // One single transfer; read data taken at the data phase's end
    task automatic bus(input logic [7:0] a, input logic w,
        input logic [31:0] d);
        haddr <= a;
        hwrite <= w;
        htrans <= cdfr_pkg::HTRANS_NSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Idle cycles after a write let registered outputs settle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
        cyc(2);
    endtask
    task automatic rchk(input string nm, input logic [7:0] a,
        input logic [31:0] e);
        bus(a, 1'b0, 32'h0000_0000);
        `CHK(nm, e, rd)
    endtask
    // Bounded wait for a level; cycle count comes back in k
    task automatic wt(ref logic s, input logic v, output int k);
        k = 0;
        while (s !== v && k < 2000) begin
            @(posedge hclk);
            k++;
        end
    endtask
    task automatic tally_and_finish();
        $display("Counts: %0d compares, %0d errors", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        cyc(20);
        `CHK("hiz_rst", 1'b1, driver_hiz)
        hresetn <= 1'b1;
        cyc(3);
        `CHK("shunt_idle", 1'b1, shunt_connect)
        `CHK("boost_idle", 1'b0, boost_switch)
        $display("reset test done");
        foreach (rows[i]) begin
            wr(cdfr_pkg::A_STEP, {27'h0, rows[i].code});
            `CHK("current_step", rows[i].eff, current_step)
            rchk("step_code", cdfr_pkg::A_STEP, {27'h0, rows[i].code});
        end
        $display("step table done");
        wr(cdfr_pkg::A_CTRL, 32'h0000_0009);
        `CHK("driver_en", 6'h04, driver_en)
        wt(boost_switch, 1'b1, c);
        wt(boost_switch, 1'b0, n);
        wt(boost_switch, 1'b0 + 1'b1, c);
        `CHK("boost_period", cdfr_pkg::BOOST_DIV, n + c)
        repeat (2) begin
            wt(shunt_zero_cross, 1'b0, c);
            wt(shunt_zero_cross, 1'b1, c);
        end
        wt(peak_sample, 1'b1, c);
        `CHK("peak_delay", 1'b1, (c >= 99 && c <= 104))
        boost_over_volt <= 1'b1;
        cyc(3);
        n = 0;
        repeat (400) begin
            cyc(1);
            if (boost_switch !== 1'b0) n++;
        end
        `CHK("boost_ov", 0, n)
        `CHK("irq_masked", 1'b0, irq)
        wr(cdfr_pkg::A_IMASK, 32'h0000_0002);
        `CHK("irq_unmasked", 1'b1, irq)
        boost_over_volt <= 1'b0;
        rchk("istat_ov", cdfr_pkg::A_ISTAT, 32'h0000_0002);
        cyc(2);
        `CHK("irq_cleared", 1'b0, irq)
        $display("boost and peak test done");
        wr(cdfr_pkg::A_IMASK, 32'h0000_0001);
        pos_short_gnd <= 6'h10;
        cyc(3);
        `CHK("hiz_fault", 1'b1, driver_hiz)
        `CHK("en_fault", 6'h00, driver_en)
        `CHK("shunt_fault", 1'b0, shunt_connect)
        `CHK("irq_fault", 1'b1, irq)
        rchk("fault_reg", cdfr_pkg::A_FAULT, 32'h0000_0090);
        rchk("stat_shut", cdfr_pkg::A_STAT, 32'h0000_0002);
        wr(cdfr_pkg::A_CTRL, 32'h0000_0009);
        `CHK("tx_ignored", 6'h00, driver_en)
        rchk("istat_fault", cdfr_pkg::A_ISTAT, 32'h0000_0001);
        wr(cdfr_pkg::A_FAULT, 32'h0000_0000);
        rchk("stat_blocked", cdfr_pkg::A_STAT, 32'h0000_0040);
        wr(cdfr_pkg::A_CTRL, 32'h0000_0009);
        `CHK("tx_resumed", 6'h04, driver_en)
        pos_short_gnd <= 6'h00;
        open_load <= 6'h04;
        cyc(3);
        `CHK("hiz_open", 1'b1, driver_hiz)
        rchk("fault_open", cdfr_pkg::A_FAULT, 32'h0000_0104);
        open_load <= 6'h00;
        wr(cdfr_pkg::A_FAULT, 32'h0000_0000);
        over_temp <= 1'b1;
        cyc(3);
        `CHK("shunt_hot", 1'b0, shunt_connect)
        bus(cdfr_pkg::A_FAULT, 1'b0, 32'h0000_0000);
        `CHK("fault_hot", 4'h8, rd[9:6])
        over_temp <= 1'b0;
        wr(cdfr_pkg::A_FAULT, 32'h0000_0000);
        $display("fault test done");
        wr(cdfr_pkg::A_CTRL, 32'h0000_0006);
        `CHK("hiz_diag", 1'b1, driver_hiz)
        wr(cdfr_pkg::A_DIAG, 32'h0000_0001);
        `CHK("diag_hi_p", 6'h02, diag_hi_p)
        `CHK("diag_hi_n", 6'h00, diag_hi_n)
        rchk("diag_line", cdfr_pkg::A_DIAG, 32'h0000_0002);
        p_to_gnd <= 6'h02;
        cyc(2);
        rchk("diag_short", cdfr_pkg::A_DIAG, 32'h0000_0000);
        wr(cdfr_pkg::A_CTRL, 32'h0000_0002);
        rchk("diag_sel", cdfr_pkg::A_CTRL, 32'h0000_0002);
        `CHK("diag_latched", 6'h02, diag_hi_p)
        wr(8'h40, 32'hFFFF_FFFF);
        rchk("unmapped", 8'h40, 32'h0000_0000);
        `CHK("hresp", 1'b0, hresp)
        $display("diag and bus test done");
        // Chip reset in mid run lifts the coil block list
        hresetn <= 1'b0;
        cyc(2);
        `CHK("hiz_rst2", 1'b1, driver_hiz)
        hresetn <= 1'b1;
        cyc(2);
        rchk("stat_rst", cdfr_pkg::A_STAT, 32'h0000_0000);
        `CHK("hi_p_rst", 6'h00, diag_hi_p)
        $display("second reset test done");
        tally_and_finish();
    end
    // Watchdog well beyond the expected run length
    initial begin
        cyc(60000);
        error_cnt++;
        tally_and_finish();
    end
endmodule
